//--- rtl/dsc_pkg.sv
package dsc_pkg;

  // ==========================================================
  // Register map (byte addresses on the Avalon-MM slave)
  // ==========================================================
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LASTCMD = 4'h8;
  localparam logic [3:0] REG_ERRCNT = 4'hC;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_INIT_BIT = 4;
  localparam int ST_GATE_BIT = 5;
  localparam int ST_NV_BIT = 6;
  localparam int ST_PREPROG_BIT = 7;
  localparam int ST_DOWN_BIT = 8;
  localparam int ST_AUX_BIT = 9;
  localparam int ST_NVMDONE_BIT = 10;
  localparam int ST_DIR_LSB = 12;
  localparam int ST_LVL_LSB = 16;
  localparam int LC_DATA_LSB = 4;
  localparam int LC_LONG_BIT = 12;
  localparam int EC_LEN_LSB = 8;

  // ==========================================================
  // Word format
  // ==========================================================
  localparam logic [4:0] SHORT_BITS = 5'h0C;
  localparam logic [4:0] LONG_BITS = 5'h14;
  localparam logic [3:0] CRC_SEED = 4'hA;
  localparam logic [3:0] CRC_POLY = 4'h3;
  localparam logic [3:0] ADDR_ZERO = 4'h0;
  localparam logic [3:0] NVM_MARK = 4'hF;

  // ==========================================================
  // Command codes
  // ==========================================================
  localparam logic [3:0] CMD_INIT = 4'h0;
  localparam logic [3:0] CMD_STATUS = 4'h1;
  localparam logic [3:0] CMD_VAL0 = 4'h2;
  localparam logic [3:0] CMD_IOCTL = 4'h3;
  localparam logic [3:0] CMD_ID = 4'h4;
  localparam logic [3:0] CMD_VAL1 = 4'h5;
  localparam logic [3:0] CMD_VAL2 = 4'h6;
  localparam logic [3:0] CMD_CLEAR = 4'h7;
  localparam logic [3:0] CMD_VAL3 = 4'h8;
  localparam logic [3:0] CMD_NVM = 4'h9;
  localparam logic [3:0] CMD_AUX_CLR = 4'hC;
  localparam logic [3:0] CMD_AUX_SET = 4'hD;
  localparam logic [3:0] CMD_REVINIT = 4'hF;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ = 200;
  localparam int TIMEOUT_US = 500;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int BIT_CNT_W = 16;

  typedef enum logic [1:0] {
    LVL_IDLE = 2'h0,
    LVL_HIGH = 2'h1,
    LVL_LOW = 2'h2
  } dsc_lvl_type;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_START = 2'h1,
    S_LOW = 2'h3,
    S_HIGH = 2'h2
  } dsc_fsm_type;

endpackage : dsc_pkg

//--- rtl/dsc_slave_decoder.sv
// Overview of operation
// - Classify each bus pin as idle, high or low; accept either pin alone.
// - Flag whether incoming signaling sits on the downstream pin.
// - Reverse init runs only uninitialized and with downstream signaling.
// - A word starts on idle to high to low; each bit low, high, low.
// - A bit is one when its high part outlasts its low part.
// - High straight to idle after the last bit ends the word.
// - CRC is computed over received words per the bus standard.
// - A CRC mismatch means no action and no response.
// - Words of other than 12 or 20 bits are discarded.
// - Runtime-programmable device powers up at address zero, gate open.
// - Init on upstream pin adopts address; closes gate at end if close bit set, or store bit set when unprogrammed.
// - Pre-programmed device keeps stored address; init must match it.
// - Init to address zero with store enable loads address, closes gate.
// - NVM command matching target and address register stores address.
// - Decode 4-bit command code; short and long commands accepted.
// - Short commands are also accepted in long format.
// - I/O control: upper nibble levels, lower nibble directions.
// - Init-type commands carry the new address in the low nibble.
// - Chain gate close bit set to one closes the gate.
// - Group bits of init-type commands are ignored.
// - Permanent programming only when store enable bit is one.
// - Response follows in the next message, same word length.
// - Once initialized, ignore init until clear or power-up.
// - Reset itself when the bus stays out of idle too long.
// - Every command ends with a 4-bit CRC checked by the device.
//
// The Avalon-MM slave port and the register offsets were decided locally.
module dsc_slave_decoder #(
  parameter int TIMEOUT_CYC = dsc_pkg::TIMEOUT_CYC,
  parameter int CNT_W = dsc_pkg::BIT_CNT_W
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic bus_upstream_pin_idle_cmp_in,
  input wire logic bus_upstream_pin_high_cmp_in,
  input wire logic bus_downstream_pin_idle_cmp_in,
  input wire logic bus_downstream_pin_high_cmp_in,
  input wire logic nvm_programmed_in,
  input wire logic [3:0] nvm_address_in,
  output logic nvm_write_out,
  output logic [3:0] nvm_wdata_out,
  output logic chain_pass_gate_out,
  output logic aux_drive_output_out,
  output logic [3:0] pin_direction_bits_out,
  output logic [3:0] aux_output_level_out,
  output logic downstream_active_out,
  output logic cmd_valid_out,
  output logic [3:0] cmd_code_out,
  output logic [7:0] cmd_data_out,
  output logic cmd_long_word_out
);
  import dsc_pkg::*;

  localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  typedef struct packed {
    dsc_fsm_type fsm;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] high_cnt;
    logic [4:0] nbits;
    logic overlong;
    logic [19:0] shreg;
    logic word_end;
    logic from_down;
    logic booted;
    logic preprog;
    logic initialized;
    logic [3:0] addr;
    logic gate;
    logic nv;
    logic nvm_done;
    logic [3:0] io_dir;
    logic [3:0] io_lvl;
    logic aux_out;
    logic nvm_wr;
    logic [3:0] nvm_data;
    logic cmd_valid;
    logic [3:0] cmd_code;
    logic [7:0] cmd_data;
    logic cmd_long;
    logic [TO_W-1:0] to_cnt;
    logic waitreq;
    logic [31:0] rdata;
    logic enable;
    logic [7:0] crc_errs;
    logic [7:0] len_errs;
  } dsc_state_type;

  dsc_state_type st_r;
  dsc_state_type st_nxt;
  dsc_lvl_type up_lvl;
  dsc_lvl_type dn_lvl;
  dsc_lvl_type bus_lvl;
  logic len_ok;
  logic is_long;
  logic crc_ok;
  logic [3:0] w_code;
  logic [3:0] w_addr;
  logic [7:0] w_data;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic dsc_lvl_type lvl_of(input logic idle_cmp,
                                         input logic high_cmp);
    if (idle_cmp)
      return LVL_IDLE;
    else if (high_cmp)
      return LVL_HIGH;
    else
      return LVL_LOW;
  endfunction : lvl_of

  // Serial CRC, MSB first; short words cover address and command only
  function automatic logic [3:0] crc4(input logic [15:0] d,
                                      input logic lng);
    logic [3:0] c;
    logic fb;
    c = CRC_SEED;
    for (int i = 15; i >= 0; i--)
    begin
      if (lng || i < 8)
      begin
        fb = c[3] ^ d[i];
        c = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
      end
    end
    return c;
  endfunction : crc4

  function automatic logic [31:0] reg_read(input logic [3:0] a,
                                           input dsc_state_type s);
    logic [31:0] v;
    v = RD_ZERO;
    case (a)
      REG_CTRL: v[CTRL_EN_BIT] = s.enable;
      REG_STATUS:
      begin
        v[3:0] = s.addr;
        v[ST_INIT_BIT] = s.initialized;
        v[ST_GATE_BIT] = s.gate;
        v[ST_NV_BIT] = s.nv;
        v[ST_PREPROG_BIT] = s.preprog;
        v[ST_DOWN_BIT] = s.from_down;
        v[ST_AUX_BIT] = s.aux_out;
        v[ST_NVMDONE_BIT] = s.nvm_done;
        v[ST_DIR_LSB +: 4] = s.io_dir;
        v[ST_LVL_LSB +: 4] = s.io_lvl;
      end
      REG_LASTCMD:
      begin
        v[3:0] = s.cmd_code;
        v[LC_DATA_LSB +: 8] = s.cmd_data;
        v[LC_LONG_BIT] = s.cmd_long;
      end
      REG_ERRCNT:
      begin
        v[7:0] = s.crc_errs;
        v[EC_LEN_LSB +: 8] = s.len_errs;
      end
      default: v = RD_ZERO;
    endcase
    return v;
  endfunction : reg_read

  // ==========================================================
  // Level sensing
  // ==========================================================
  // pin classification
  assign up_lvl = lvl_of(bus_upstream_pin_idle_cmp_in,
                         bus_upstream_pin_high_cmp_in);
  assign dn_lvl = lvl_of(bus_downstream_pin_idle_cmp_in,
                         bus_downstream_pin_high_cmp_in);
  // Upstream wins when both pins carry signaling
  assign bus_lvl = (up_lvl != LVL_IDLE) ? up_lvl : dn_lvl;

  // ==========================================================
  // Word checks
  // ==========================================================
  assign is_long = (st_r.nbits == LONG_BITS);
  assign len_ok = !st_r.overlong &&
                  (st_r.nbits == SHORT_BITS || is_long);
  assign crc_ok = (crc4(is_long ? st_r.shreg[19:4]
                                : {8'h00, st_r.shreg[11:4]}, is_long)
                   == st_r.shreg[3:0]);
  assign w_code = st_r.shreg[7:4];
  assign w_addr = st_r.shreg[11:8];
  assign w_data = is_long ? st_r.shreg[19:12] : 8'h00;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    logic bit_val;
    logic accept;
    bit_val = 1'b0;
    accept = 1'b0;
    st_nxt = st_r;
    st_nxt.word_end = 1'b0;
    st_nxt.cmd_valid = 1'b0;
    st_nxt.nvm_wr = 1'b0;

    // Slave: one wait cycle, answer on the following edge
    st_nxt.waitreq = 1'b1;
    if ((avs_read_in || avs_write_in) && st_r.waitreq)
    begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata = reg_read(avs_address_in, st_r);
    end
    if (avs_write_in && !st_r.waitreq)
    begin
      if (avs_address_in == REG_CTRL && avs_byteenable_in[0])
        st_nxt.enable = avs_writedata_in[CTRL_EN_BIT];
      if (avs_address_in == REG_ERRCNT)
      begin
        st_nxt.crc_errs = 8'h00;
        st_nxt.len_errs = 8'h00;
      end
    end

    // address taken after reset from stored value, or zero when unprogrammed
    if (!st_r.booted)
    begin
      st_nxt.booted = 1'b1;
      st_nxt.preprog = nvm_programmed_in;
      st_nxt.nvm_done = nvm_programmed_in;
      st_nxt.addr = nvm_programmed_in ? nvm_address_in : ADDR_ZERO;
    end

    case (st_r.fsm)
      S_IDLE:
        if (st_r.enable && bus_lvl == LVL_HIGH)
          st_nxt.fsm = S_START;
      S_START:
        if (bus_lvl == LVL_LOW)
        begin
          st_nxt.fsm = S_LOW;
          st_nxt.low_cnt = '0;
          st_nxt.high_cnt = '0;
          st_nxt.nbits = 5'h00;
          st_nxt.overlong = 1'b0;
          st_nxt.shreg = 20'h0_0000;
          st_nxt.from_down = (up_lvl == LVL_IDLE);
        end
        else if (bus_lvl == LVL_IDLE)
          st_nxt.fsm = S_IDLE;
      S_LOW:
        if (bus_lvl == LVL_HIGH)
          st_nxt.fsm = S_HIGH;
        else if (bus_lvl == LVL_IDLE)
          st_nxt.fsm = S_IDLE;
        else if (st_r.low_cnt != CNT_MAX)
          st_nxt.low_cnt = st_r.low_cnt + 1'b1;
      S_HIGH:
      begin
        bit_val = (st_r.high_cnt > st_r.low_cnt);
        if (bus_lvl == LVL_HIGH)
        begin
          if (st_r.high_cnt != CNT_MAX)
            st_nxt.high_cnt = st_r.high_cnt + 1'b1;
        end
        else
        begin
          st_nxt.shreg = {st_r.shreg[18:0], bit_val};
          if (st_r.nbits == LONG_BITS)
            st_nxt.overlong = 1'b1;
          else
            st_nxt.nbits = st_r.nbits + 1'b1;
          st_nxt.low_cnt = '0;
          st_nxt.high_cnt = '0;
          if (bus_lvl == LVL_IDLE)
          begin
            st_nxt.fsm = S_IDLE;
            st_nxt.word_end = 1'b1;
          end
          else
            st_nxt.fsm = S_LOW;
        end
      end
      default: st_nxt.fsm = S_IDLE;
    endcase

    // Command execution, one cycle after the word ends
    if (st_r.word_end)
    begin
      // bad words leave no trace but the error counters
      if (!len_ok)
        st_nxt.len_errs = st_r.len_errs + 8'h01;
      else if (!crc_ok)
        st_nxt.crc_errs = st_r.crc_errs + 8'h01;
      else
      begin
        case (w_code)
          CMD_INIT, CMD_REVINIT:
            if (is_long && !st_r.initialized &&
                (st_r.from_down == (w_code == CMD_REVINIT)))
            begin
              // pre-programmed devices must be named exactly
              if (st_r.preprog)
                accept = (w_addr == st_r.addr);
              else
              begin
                accept = (w_addr == ADDR_ZERO);
                if (accept)
                  st_nxt.addr = w_data[3:0];
              end
              if (accept)
              begin
                st_nxt.initialized = 1'b1;
                st_nxt.nv = w_data[7];
                if (w_data[6] || (w_data[7] && !st_r.preprog))
                  st_nxt.gate = 1'b1;
              end
            end
          default:
            // other commands need our own address
            if (st_r.initialized && w_addr == st_r.addr)
              case (w_code)
                CMD_IOCTL:
                  if (is_long)
                  begin
                    st_nxt.io_lvl = w_data[7:4];
                    st_nxt.io_dir = w_data[3:0];
                    accept = 1'b1;
                  end
                CMD_NVM:
                  if (is_long)
                  begin
                    accept = 1'b1;
                    if (st_r.nv && !st_r.nvm_done &&
                        w_data[7:4] == NVM_MARK &&
                        w_data[3:0] == w_addr)
                    begin
                      st_nxt.nvm_wr = 1'b1;
                      st_nxt.nvm_data = w_addr;
                      st_nxt.nvm_done = 1'b1;
                    end
                  end
                CMD_CLEAR:
                begin
                  st_nxt.initialized = 1'b0;
                  st_nxt.io_dir = 4'h0;
                  st_nxt.io_lvl = 4'h0;
                  st_nxt.aux_out = 1'b0;
                end
                CMD_STATUS, CMD_VAL0, CMD_VAL1, CMD_VAL2, CMD_VAL3,
                CMD_ID:
                  accept = 1'b1;
                CMD_AUX_CLR, CMD_AUX_SET:
                begin
                  st_nxt.aux_out = (w_code == CMD_AUX_SET);
                  accept = 1'b1;
                end
                default: accept = 1'b0;
              endcase
        endcase
        // the encoder answers next message at this length
        if (accept)
        begin
          st_nxt.cmd_valid = 1'b1;
          st_nxt.cmd_code = w_code;
          st_nxt.cmd_data = w_data;
          st_nxt.cmd_long = is_long;
        end
      end
    end

    // watchdog on time spent out of idle
    if (bus_lvl == LVL_IDLE)
      st_nxt.to_cnt = '0;
    else if (st_r.to_cnt == TO_LAST)
    begin
      st_nxt.to_cnt = '0;
      st_nxt.fsm = S_IDLE;
      st_nxt.booted = 1'b0;
      st_nxt.initialized = 1'b0;
      st_nxt.gate = 1'b0;
      st_nxt.nv = 1'b0;
      st_nxt.io_dir = 4'h0;
      st_nxt.io_lvl = 4'h0;
      st_nxt.aux_out = 1'b0;
      st_nxt.word_end = 1'b0;
      st_nxt.cmd_valid = 1'b0;
      st_nxt.nvm_wr = 1'b0;
    end
    else
      st_nxt.to_cnt = st_r.to_cnt + 1'b1;
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_r <= '0;
      st_r.fsm <= S_IDLE;
      st_r.waitreq <= 1'b1;
      st_r.enable <= CTRL_EN_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign avs_readdata_out = st_r.rdata;
  assign avs_waitrequest_out = st_r.waitreq;
  assign nvm_write_out = st_r.nvm_wr;
  assign nvm_wdata_out = st_r.nvm_data;
  assign chain_pass_gate_out = st_r.gate;
  assign aux_drive_output_out = st_r.aux_out;
  assign pin_direction_bits_out = st_r.io_dir;
  assign aux_output_level_out = st_r.io_lvl;
  assign downstream_active_out = st_r.from_down;
  assign cmd_valid_out = st_r.cmd_valid;
  assign cmd_code_out = st_r.cmd_code;
  assign cmd_data_out = st_r.cmd_data;
  assign cmd_long_word_out = st_r.cmd_long;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_no_direct_low: assert property (
    st_r.fsm == S_IDLE |=> st_r.fsm != S_LOW)
    else $error("word started without signal-high");

  a_bit_decision: assert property (
    (st_r.fsm == S_HIGH && bus_lvl == LVL_LOW && st_r.to_cnt != TO_LAST)
    |=> st_r.shreg[0] == ($past(st_r.high_cnt) > $past(st_r.low_cnt)))
    else $error("bit value does not follow high versus low time");

  a_word_end: assert property (
    (st_r.fsm == S_HIGH && bus_lvl == LVL_IDLE && st_r.to_cnt != TO_LAST)
    |=> st_r.word_end ##1 !st_r.word_end)
    else $error("high to idle did not end the word");

  a_len_discard: assert property (
    (st_r.word_end && !len_ok) |=> !st_r.cmd_valid && !st_r.nvm_wr &&
    $stable(st_r.addr) && $stable(st_r.io_dir))
    else $error("word of wrong length was acted on");

  a_crc_discard: assert property (
    (st_r.word_end && len_ok && !crc_ok) |=> !st_r.cmd_valid &&
    $stable(st_r.initialized) && $stable(st_r.gate))
    else $error("word with bad crc was acted on");

  a_rev_init_guard: assert property (
    (st_r.word_end && len_ok && crc_ok && w_code == CMD_REVINIT &&
     !st_r.from_down) |=> !st_r.cmd_valid)
    else $error("reverse init acted on without downstream signal");

  a_gate_at_end: assert property (
    $rose(st_r.gate) |-> $past(st_r.word_end, 1))
    else $error("chain gate closed outside a word end");

  a_init_once: assert property (
    (st_r.word_end && st_r.initialized && w_code == CMD_INIT &&
     st_r.to_cnt != TO_LAST) |=> $stable(st_r.addr) && !st_r.cmd_valid)
    else $error("initialized device took another init");

  a_nvm_guard: assert property (
    st_r.nvm_wr |-> st_r.nv && st_r.nvm_data == st_r.addr &&
    st_r.nvm_done ##1 !st_r.nvm_wr)
    else $error("permanent store without matching address");

  a_timeout_reset: assert property (
    (bus_lvl != LVL_IDLE && st_r.to_cnt == TO_LAST) |=>
    st_r.fsm == S_IDLE && !st_r.initialized && !st_r.gate)
    else $error("watchdog did not reset the device");

  a_bus_one_wait: assert property (
    ((avs_read_in || avs_write_in) && st_r.waitreq) |=>
    !st_r.waitreq ##1 st_r.waitreq)
    else $error("bus answer not one cycle after request");

  c_init_done: cover property (
    st_r.word_end ##1 (st_r.cmd_valid && st_r.cmd_code == CMD_INIT));
  c_rev_init: cover property (
    st_r.cmd_valid && st_r.cmd_code == CMD_REVINIT);
  c_nvm_store: cover property (st_r.nvm_wr);
  c_crc_reject: cover property (st_r.word_end && len_ok && !crc_ok);

endmodule : dsc_slave_decoder

//--- bench/dsc_master_model.sv
module dsc_master_model (
  input wire logic mclk_in,
  output logic up_idle_out,
  output logic up_high_out,
  output logic dn_idle_out,
  output logic dn_high_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================================================
  // Pin levels, {idle, high}: idle 11, high 01, low 00
  // ====================================================
  // Unused pin sits idle so only one side ever signals
  initial {up_idle_out, up_high_out, dn_idle_out, dn_high_out} = 4'hF;

  task automatic lvl(input bit dn, input logic [1:0] v, input int n);
    repeat (n)
    begin
      @(posedge mclk_in);
      if (dn)
        {dn_idle_out, dn_high_out} <= v;
      else
        {up_idle_out, up_high_out} <= v;
    end
  endtask : lvl

  task automatic send(input logic [19:0] w, input int nb, input bit dn,
    input int u);
    lvl(dn, 2'b01, 1);
    for (int i = nb - 1; i >= 0; i--)
    begin
      lvl(dn, 2'b00, w[i] ? u : 2 * u);
      lvl(dn, 2'b01, w[i] ? 2 * u : u);
    end
    lvl(dn, 2'b11, 4);
  endtask : send
endmodule : dsc_master_model

//--- bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsc_pkg::*;
  // Short timeout keeps the out-of-idle watchdog reachable in a short run
  localparam int TO = 2000;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic nvp = 1'b0;
  logic [3:0] nva = 4'h0;
  logic [31:0] rdat, r;
  logic wreq, ui, uh, di, dh, nvw, gate, aux, dna, cv, lw;
  logic [3:0] dir, lvo, nwd, code;
  logic [7:0] cdat, d;
  logic [3:0] sc[8] = '{CMD_STATUS, CMD_VAL0, CMD_ID, CMD_VAL1, CMD_VAL2,
    CMD_VAL3, CMD_AUX_SET, CMD_AUX_CLR};
  int bad_count = 0;
  int n_compared = 0;
  int nv_cnt = 0;
  int nvm_cnt = 0;
  integer seed = 32418;

  always #2.5 mclk_in = ~mclk_in;
  // Pulses last one cycle, so they are counted at every edge
  always @(posedge mclk_in)
  begin
    if (cv === 1'b1)
      nv_cnt++;
    if (nvw === 1'b1)
      nvm_cnt++;
  end

  dsc_master_model dsc_master_model_i (.mclk_in(mclk_in),
    .up_idle_out(ui), .up_high_out(uh), .dn_idle_out(di), .dn_high_out(dh));

  dsc_slave_decoder #(.TIMEOUT_CYC(TO)) dsc_slave_decoder_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .bus_upstream_pin_idle_cmp_in(ui),
    .bus_upstream_pin_high_cmp_in(uh), .bus_downstream_pin_idle_cmp_in(di),
    .bus_downstream_pin_high_cmp_in(dh), .nvm_programmed_in(nvp),
    .nvm_address_in(nva), .nvm_write_out(nvw), .nvm_wdata_out(nwd),
    .chain_pass_gate_out(gate), .aux_drive_output_out(aux),
    .pin_direction_bits_out(dir), .aux_output_level_out(lvo),
    .downstream_active_out(dna), .cmd_valid_out(cv), .cmd_code_out(code),
    .cmd_data_out(cdat), .cmd_long_word_out(lw));

  // ====================================================
  // Helpers
  // ====================================================
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge mclk_in);
    adr <= a;
    wd <= v;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge mclk_in);
      k++;
    end
    while (wreq !== 1'b0 && k < 20);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 20)
    begin
      bad_count++;
      close_out();
    end
  endtask : bus

  task automatic st(input logic [5:0] e);
    bus(0, REG_STATUS, 32'h0000_0000);
    chk(32'(r[5:0]), 32'(e));
  endtask : st

  // CRC seeded, MSB first over data, address, code
  function automatic logic [19:0] mk(input logic [3:0] c, input logic [3:0] a,
    input logic [7:0] v, input bit l);
    logic [15:0] p;
    logic [3:0] x;
    p = l ? {v, a, c} : {8'h00, a, c};
    x = CRC_SEED;
    for (int i = (l ? 15 : 7); i >= 0; i--)
      x = {x[2:0], 1'b0} ^ ((x[3] ^ p[i]) ? CRC_POLY : 4'h0);
    return l ? {p, x} : {8'h00, p[7:0], x};
  endfunction : mk

  task automatic word(input logic [3:0] c, input logic [3:0] a,
    input logic [7:0] v, input bit l, input bit dn, input bit ok, input bit f);
    int n0;
    n0 = nv_cnt;
    dsc_master_model_i.send(mk(c, a, v, l) ^ 20'(f), l ? 20 : 12, dn,
      1 + $unsigned($random(seed)) % 3);
    repeat (2) @(posedge mclk_in);
    chk(32'(nv_cnt - n0), 32'(ok));
    if (ok)
      chk(32'({lw, cdat, code}), 32'({l, l ? v : 8'h00, c}));
  endtask : word

  // ====================================================
  // Main sequence
  // ====================================================
  initial
  begin
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    st(6'h00);
    word(CMD_STATUS, 0, 0, 0, 0, 0, 1);
    dsc_master_model_i.send(mk(CMD_INIT, 0, 8'h45, 1), 13, 0, 2);
    bus(0, REG_ERRCNT, 0);
    chk(32'(r[15:0]), 32'h0000_0101);
    bus(1, REG_ERRCNT, 0);
    bus(0, REG_ERRCNT, 0);
    chk(r, 32'h0000_0000);
    word(CMD_REVINIT, 0, 8'h03, 1, 0, 0, 0);
    word(CMD_INIT, 0, 8'h45, 1, 0, 1, 0);
    st(6'h35);
    chk(32'({gate, dna}), 32'h0000_0002);
    word(CMD_INIT, 5, 8'h49, 1, 0, 0, 0);
    st(6'h35);
    repeat (4)
    begin
      d = 8'($random(seed));
      word(CMD_IOCTL, 5, d, 1, 0, 1, 0);
      chk(32'({lvo, dir}), 32'(d));
    end
    word(CMD_IOCTL, 6, 8'h00, 1, 0, 0, 0);
    for (int i = 0; i < 16; i++)
    begin
      word(sc[i / 2], 5, 0, i[0], 0, 1, 0);
      if (sc[i / 2] == CMD_AUX_SET)
        chk(32'(aux), 1);
    end
    chk(32'(aux), 0);
    dsc_master_model_i.lvl(0, 2'b00, TO + 10);
    dsc_master_model_i.lvl(0, 2'b11, 4);
    st(6'h00);
    word(CMD_INIT, 0, 8'hB6, 1, 0, 1, 0);
    st(6'h36);
    word(CMD_NVM, 6, 8'hF6, 1, 0, 1, 0);
    chk(32'({nwd, 4'(nvm_cnt)}), 32'h0000_0061);
    dsc_master_model_i.lvl(0, 2'b00, TO + 10);
    dsc_master_model_i.lvl(0, 2'b11, 4);
    word(CMD_REVINIT, 0, 8'h03, 1, 1, 1, 0);
    chk(32'(dna), 1);
    st(6'h13);
    word(CMD_CLEAR, 3, 0, 0, 0, 0, 0);
    st(6'h03);
    // Second reset with a stored address: pre-programmed start
    rst_in <= 1'b1;
    nvp <= 1'b1;
    nva <= 4'h9;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    bus(0, REG_STATUS, 0);
    chk(32'(r[7:0]), 32'h0000_0089);
    word(CMD_INIT, 2, 8'h49, 1, 0, 0, 0);
    word(CMD_INIT, 9, 8'h49, 1, 0, 1, 0);
    bus(0, REG_STATUS, 0);
    chk(32'(r[7:0]), 32'h0000_00B9);
    chk(32'({gate, dna}), 32'h0000_0002);
    bus(0, REG_LASTCMD, 0);
    chk(32'(r[12:0]), 32'h0000_1490);
    // Decoder disabled: a good word must leave no trace
    bus(1, REG_CTRL, 32'h0000_0000);
    word(CMD_STATUS, 9, 0, 0, 0, 0, 0);
    bus(1, REG_CTRL, 32'h0000_0001);
    bus(0, REG_CTRL, 0);
    chk(r, 32'h0000_0001);
    word(CMD_STATUS, 9, 0, 0, 0, 1, 0);
    bus(0, 4'h2, 0);
    chk(r, 32'h0000_0000);
    close_out();
  end
endmodule : tb_top
